// ==== inc/ucp_defines.vh ====
// register offsets, field positions, reset values and cell sizes of the cell port
// assumes inclusion by bare name from the design file
`ifndef UCP_DEFINES_VH
`define UCP_DEFINES_VH

`define UCP_OFS_MCR      8'h00
`define UCP_OFS_STATUS   8'h04
`define UCP_OFS_CTRL     8'h08
`define UCP_OFS_ECR0     8'h10
`define UCP_OFS_TXPTR    8'h20
`define UCP_OFS_TXDATA   8'h24
`define UCP_OFS_RXPTR    8'h28
`define UCP_OFS_RXDATA   8'h2C

`define UCP_MCR_BYTE_BIT 1
`define UCP_MCR_RESET    2'h0
`define UCP_ADDR_MSB     4

`define UCP_MODE_L2      2'h0
`define UCP_MODE_L1      2'h1
`define UCP_MODE_DPI     2'h2

`define UCP_L2_WORDS     6'd27
`define UCP_L1_BYTES     6'd53
`define UCP_HDR_BYTES    6'd5
`define UCP_MEM_BYTES    54

`endif

// ==== design/ucp_cell_port.v ====
// PHY-side cell transfer port: 16-bit multi-address and 8-bit multi-PHY modes, APB registers
// assumes link clocks and pins asynchronous to clk_i and much slower (8+ clk_i cycles per period)
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/100ps
`include "ucp_defines.vh"

module ucp_cell_port
(
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output reg         pslverr_o,
  input  wire [1:0]  mode_i,
  input  wire        txclk_i,
  input  wire [15:0] txdata_i,
  input  wire        txprty_i,
  input  wire        txsoc_i,
  input  wire [4:0]  txaddr_i,
  input  wire [3:0]  txen_n_i,
  output reg  [3:0]  txclav_o,
  output reg  [3:0]  txclav_oe_o,
  input  wire        rxclk_i,
  input  wire [4:0]  rxaddr_i,
  input  wire [3:0]  rxen_n_i,
  output reg  [15:0] rxdata_o,
  output reg         rxprty_o,
  output reg         rxsoc_o,
  output reg         rxdata_oe_o,
  output reg  [3:0]  rxclav_o,
  output reg  [3:0]  rxclav_oe_o
);

  // three-stage sampling of every pin; a change counts once stages 2 and 3 agree
  localparam SW = 40;
  wire [SW-1:0] pin_raw = {mode_i, rxclk_i, rxaddr_i, rxen_n_i,
                           txclk_i, txdata_i, txprty_i, txsoc_i, txaddr_i, txen_n_i};
  reg  [SW-1:0] s1;
  reg  [SW-1:0] s2;
  reg  [SW-1:0] s3;
  reg  [SW-1:0] pin;
  always @(posedge clk_i)
  begin
    s1  <= pin_raw;
    s2  <= s1;
    s3  <= s2;
    pin <= (s2 & s3) | (pin & (s2 | s3));
  end

  wire [1:0]  mode    = pin[39:38];
  wire        rclk    = pin[37];
  wire [4:0]  raddr   = pin[36:32];
  wire [3:0]  ren_n   = pin[31:28];
  wire        tclk    = pin[27];
  wire [15:0] tdata   = pin[26:11];
  wire        tprty   = pin[10];
  wire        tsoc    = pin[9];
  wire [4:0]  taddr   = pin[8:4];
  wire [3:0]  ten_n   = pin[3:0];

  reg         tclk_q;
  reg         rclk_q;
  wire        tedge   = tclk & ~tclk_q;
  wire        redge   = rclk & ~rclk_q;
  wire        is_l2   = (mode == `UCP_MODE_L2);
  wire        is_l1   = (mode == `UCP_MODE_L1);
  // DPI and the reserved code leave the cell port idle: outputs released

  // registers
  reg  [1:0]  mcr;
  reg  [4:0]  ecr [0:3];
  reg  [3:0]  tx_full;
  reg  [3:0]  rx_ready;
  reg         tx_perr;
  reg  [4:0]  tx_ptr;
  reg  [4:0]  rx_ptr;
  reg  [7:0]  tx_mem [0:`UCP_MEM_BYTES-1];
  reg  [7:0]  rx_mem [0:`UCP_MEM_BYTES-1];
  wire        byte_mode = mcr[`UCP_MCR_BYTE_BIT];

  wire        acc     = psel_i & penable_i;
  wire        wr      = acc & pwrite_i;
  assign pready_o = 1'b1;

  // 8-bit stream index to memory byte: skips the stuff byte after the header
  function [5:0] l1_map;
    input [5:0] b;
    begin
      l1_map = (b < `UCP_HDR_BYTES) ? b : b + 6'd1;
    end
  endfunction

  // channel whose address matches a bus address, with hit flag
  function [2:0] match;
    input [4:0] a;
    input [4:0] e0;
    input [4:0] e1;
    input [4:0] e2;
    input [4:0] e3;
    begin
      if (a == e0)
        match = 3'h4;
      else if (a == e1)
        match = 3'h5;
      else if (a == e2)
        match = 3'h6;
      else if (a == e3)
        match = 3'h7;
      else
        match = 3'h0;
    end
  endfunction

  wire [2:0] tmatch = match(taddr, ecr[0], ecr[1], ecr[2], ecr[3]);
  wire [2:0] rmatch = match(raddr, ecr[0], ecr[1], ecr[2], ecr[3]);

  // lowest enabled channel in 8-bit mode; one enable expected at a time
  function [2:0] first_en;
    input [3:0] en_n;
    begin
      if (!en_n[0])
        first_en = 3'h4;
      else if (!en_n[1])
        first_en = 3'h5;
      else if (!en_n[2])
        first_en = 3'h6;
      else if (!en_n[3])
        first_en = 3'h7;
      else
        first_en = 3'h0;
    end
  endfunction

  // transmit side
  reg  [2:0]  tx_cand;
  reg  [1:0]  tx_ch;
  reg         tx_en_q;
  reg         tx_busy;
  reg  [5:0]  tx_cnt;
  reg  [3:0]  tx_done;
  wire [2:0]  tx_l1ch  = first_en(ten_n);
  wire [1:0]  tx_wch   = is_l2 ? tx_ch : tx_l1ch[1:0];
  wire        tx_sel   = is_l2 ? (!ten_n[0] && (tx_busy || tx_cand[2] || tsoc)) : tx_l1ch[2];
  // byte mode lets the room flag stop each byte; cell mode never checks it, not even at the start of a cell
  wire        tx_gate  = is_l1 && byte_mode && tx_full[tx_wch];
  wire        tx_take  = tedge && (is_l2 || is_l1) && tx_sel && !tx_gate;
  wire [5:0]  tx_pos   = tsoc ? 6'd0 : tx_cnt;
  wire [5:0]  tx_last  = is_l2 ? `UCP_L2_WORDS - 6'd1 : `UCP_L1_BYTES - 6'd1;
  wire        tx_par   = is_l2 ? ^{tdata, tprty} : ^{tdata[7:0], tprty};

  integer i;
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      tclk_q  <= 1'b0;
      tx_cand <= 3'h0;
      tx_ch   <= 2'h0;
      tx_en_q <= 1'b1;
      tx_busy <= 1'b0;
      tx_cnt  <= 6'h0;
      tx_done <= 4'h0;
      tx_perr <= 1'b0;
    end
    else
    begin
      tclk_q  <= tclk;
      tx_done <= 4'h0;
      if (wr && paddr_i == `UCP_OFS_CTRL && pwdata_i[8])
        tx_perr <= 1'b0;
      if (tedge)
      begin
        tx_en_q <= ten_n[0];
        // address seen while enable high names the next selection
        if (ten_n[0])
          tx_cand <= tmatch;
        else if (tx_en_q)
        begin
          tx_ch   <= tx_cand[1:0];
          tx_cand <= {1'b0, tx_cand[1:0]};
        end
      end
      if (tx_take)
      begin
        if (tx_en_q && is_l2 && tx_cand[2])
          tx_ch <= tx_cand[1:0];
        if (!tx_par)
          tx_perr <= 1'b1;
        if (tx_pos == tx_last)
        begin
          tx_busy <= 1'b0;
          tx_cnt  <= 6'h0;
          tx_done[is_l2 && tx_en_q && tx_cand[2] ? tx_cand[1:0] : tx_wch] <= 1'b1;
        end
        else
        begin
          tx_busy <= 1'b1;
          tx_cnt  <= tx_pos + 6'd1;
        end
      end
    end
  end

  // captured cell; 16-bit words put the earlier byte high
  always @(posedge clk_i)
  begin
    if (tx_take)
    begin
      if (is_l2)
      begin
        tx_mem[{tx_pos[4:0], 1'b0}] <= tdata[15:8];
        tx_mem[{tx_pos[4:0], 1'b1}] <= tdata[7:0];
      end
      else
        tx_mem[l1_map(tx_pos)] <= tdata[7:0];
    end
    if (wr && paddr_i == `UCP_OFS_RXDATA)
    begin
      rx_mem[{rx_ptr, 1'b0}] <= pwdata_i[15:8];
      rx_mem[{rx_ptr, 1'b1}] <= pwdata_i[7:0];
    end
  end

  // receive side
  reg  [2:0]  rx_cand;
  reg  [1:0]  rx_ch;
  reg         rx_en_q;
  reg  [5:0]  rx_cnt;
  reg  [3:0]  rx_done;
  wire [2:0]  rx_l1ch  = first_en(ren_n);
  wire [1:0]  rx_wch   = is_l2 ? ((rx_en_q && rx_cand[2]) ? rx_cand[1:0] : rx_ch) : rx_l1ch[1:0];
  wire        rx_sel   = is_l2 ? !ren_n[0] : rx_l1ch[2];
  wire        rx_mid   = (rx_cnt != 6'd0);
  // a cell is only started when ready; byte mode also stalls on a cleared flag
  wire        rx_gate  = !rx_ready[rx_wch] && (!rx_mid || (is_l1 && byte_mode));
  wire        rx_give  = redge && (is_l2 || is_l1) && rx_sel && !rx_gate;
  wire [5:0]  rx_last  = is_l2 ? `UCP_L2_WORDS - 6'd1 : `UCP_L1_BYTES - 6'd1;
  wire [15:0] rx_word  = is_l2 ? {rx_mem[{rx_cnt[4:0], 1'b0}], rx_mem[{rx_cnt[4:0], 1'b1}]}
                               : {8'h00, rx_mem[l1_map(rx_cnt)]};

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      rclk_q      <= 1'b0;
      rx_cand     <= 3'h0;
      rx_ch       <= 2'h0;
      rx_en_q     <= 1'b1;
      rx_cnt      <= 6'h0;
      rx_done     <= 4'h0;
      rxdata_o    <= 16'h0000;
      rxprty_o    <= 1'b1;
      rxsoc_o     <= 1'b0;
      rxdata_oe_o <= 1'b0;
    end
    else
    begin
      rclk_q  <= rclk;
      rx_done <= 4'h0;
      if (redge)
      begin
        rx_en_q     <= ren_n[0];
        rxsoc_o     <= 1'b0;
        rxdata_oe_o <= (is_l2 || is_l1) && rx_sel;
        if (ren_n[0])
          rx_cand <= rmatch;
        else if (rx_en_q)
        begin
          rx_ch   <= rx_cand[1:0];
          rx_cand <= {1'b0, rx_cand[1:0]};
        end
      end
      if (rx_give)
      begin
        rxdata_o <= rx_word;
        rxprty_o <= ~^rx_word;
        rxsoc_o  <= (rx_cnt == 6'd0);
        if (rx_cnt == rx_last)
        begin
          rx_cnt           <= 6'h0;
          rx_done[rx_wch]  <= 1'b1;
        end
        else
          rx_cnt <= rx_cnt + 6'd1;
      end
    end
  end

  // cell-available: 16-bit mode answers the polled address on the next link clock
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      txclav_o    <= 4'h0;
      txclav_oe_o <= 4'h0;
      rxclav_o    <= 4'h0;
      rxclav_oe_o <= 4'h0;
    end
    else
    begin
      if (!(is_l2 || is_l1))
      begin
        txclav_oe_o <= 4'h0;
        rxclav_oe_o <= 4'h0;
      end
      else if (is_l2)
      begin
        if (tedge)
        begin
          txclav_o    <= {3'h0, tmatch[2] & ~tx_full[tmatch[1:0]]};
          txclav_oe_o <= {3'h0, tmatch[2]};
        end
        if (redge)
        begin
          rxclav_o    <= {3'h0, rmatch[2] & rx_ready[rmatch[1:0]]};
          rxclav_oe_o <= {3'h0, rmatch[2]};
        end
      end
      else
      begin
        if (tedge)
        begin
          txclav_o    <= ~tx_full;
          txclav_oe_o <= 4'hF;
        end
        if (redge)
        begin
          rxclav_o    <= rx_ready;
          rxclav_oe_o <= 4'hF;
        end
      end
    end
  end

  // APB registers; link events win over software in the same cycle, except that a software set of rx_ready beats a cell-done clear
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      mcr      <= `UCP_MCR_RESET;
      tx_full  <= 4'h0;
      rx_ready <= 4'h0;
      tx_ptr   <= 5'h00;
      rx_ptr   <= 5'h00;
      for (i = 0; i < 4; i = i + 1)
        ecr[i] <= i[4:0];
    end
    else
    begin
      if (wr && paddr_i == `UCP_OFS_MCR)
        mcr <= pwdata_i[1:0];
      else if (wr && paddr_i[7:4] == 4'h1 && paddr_i[1:0] == 2'h0)
        ecr[paddr_i[3:2]] <= pwdata_i[`UCP_ADDR_MSB:0];
      else if (wr && paddr_i == `UCP_OFS_TXPTR)
        tx_ptr <= pwdata_i[4:0];
      else if (wr && paddr_i == `UCP_OFS_RXPTR)
        rx_ptr <= pwdata_i[4:0];
      else if (wr && paddr_i == `UCP_OFS_RXDATA)
        rx_ptr <= rx_ptr + 5'd1;
      else if (acc && !pwrite_i && paddr_i == `UCP_OFS_TXDATA)
        tx_ptr <= tx_ptr + 5'd1;
      if (wr && paddr_i == `UCP_OFS_CTRL)
      begin
        tx_full  <= (tx_full & ~pwdata_i[3:0]) | tx_done;
        rx_ready <= (rx_ready & ~rx_done) | pwdata_i[7:4];
      end
      else
      begin
        tx_full  <= tx_full | tx_done;
        rx_ready <= rx_ready & ~rx_done;
      end
    end
  end

  always @*
  begin
    prdata_o  = 32'h0000_0000;
    pslverr_o = 1'b0;
    if (paddr_i == `UCP_OFS_MCR)
      prdata_o = {30'h0, mcr};
    else if (paddr_i == `UCP_OFS_STATUS)
      prdata_o = {19'h0, tx_perr, rx_ready, tx_full, 2'h0, mode};
    else if (paddr_i == `UCP_OFS_CTRL)
      prdata_o = 32'h0000_0000;
    else if (paddr_i[7:4] == 4'h1 && paddr_i[1:0] == 2'h0)
      prdata_o = {27'h0, ecr[paddr_i[3:2]]};
    else if (paddr_i == `UCP_OFS_TXPTR)
      prdata_o = {27'h0, tx_ptr};
    else if (paddr_i == `UCP_OFS_TXDATA)
      prdata_o = {16'h0, tx_mem[{tx_ptr, 1'b0}], tx_mem[{tx_ptr, 1'b1}]};
    else if (paddr_i == `UCP_OFS_RXPTR)
      prdata_o = {27'h0, rx_ptr};
    else if (paddr_i == `UCP_OFS_RXDATA)
      prdata_o = 32'h0000_0000;
    else
      pslverr_o = psel_i & penable_i;
  end

endmodule

// ==== test/ucp_cell_port_chk.sv ====
// pin-level checker of the cell port
// assumes it is bound into ucp_cell_port and sees only its ports
`timescale 1ns/100ps
module ucp_cell_port_chk
(
  input wire        clk_i,
  input wire        reset_n_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        txclk_i,
  input wire        rxclk_i,
  input wire [3:0]  txclav_o,
  input wire [15:0] rxdata_o,
  input wire        rxprty_o,
  input wire        rxsoc_o,
  input wire        rxdata_oe_o
);
  reg [1:0] tx_d;
  reg [1:0] rx_d;
  reg [3:0] since_tx;
  reg [3:0] since_rx;
  // cycles since a link edge; outputs may only move shortly after one
  always @(posedge clk_i)
  begin
    tx_d <= {tx_d[0], txclk_i};
    rx_d <= {rx_d[0], rxclk_i};
    since_tx <= !reset_n_i ? 4'hF : (tx_d == 2'h1) ? 4'h0 : since_tx + {3'h0, since_tx != 4'hF};
    since_rx <= !reset_n_i ? 4'hF : (rx_d == 2'h1) ? 4'h0 : since_rx + {3'h0, since_rx != 4'hF};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_ready; pready_o; endproperty
  property p_err; pslverr_o |-> psel_i && penable_i && prdata_o == 32'h0; endproperty
  property p_par; rxprty_o == ~^rxdata_o; endproperty
  property p_soc_hold; $rose(rxsoc_o) |=> rxsoc_o [*4]; endproperty
  property p_soc_oe; rxsoc_o |-> rxdata_oe_o; endproperty
  property p_rx_sync; $changed(rxdata_o) |-> since_rx < 4'h7; endproperty
  property p_tx_sync; $changed(txclav_o) |-> since_tx < 4'h7; endproperty
  property p_rx_stable; $changed(rxdata_o) |=> $stable(rxdata_o) [*5]; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err: assert property (p_err) else $error("slave error outside access or with data");
  a_par: assert property (p_par) else $error("receive parity not odd");
  a_soc_hold: assert property (p_soc_hold) else $error("start of cell too short");
  a_soc_oe: assert property (p_soc_oe) else $error("start of cell while not driving");
  a_rx_sync: assert property (p_rx_sync) else $error("receive data moved off link edge");
  a_tx_sync: assert property (p_tx_sync) else $error("cell available moved off link edge");
  a_rx_stable: assert property (p_rx_stable) else $error("receive data moved twice in a period");
  c_soc: cover property ($rose(rxsoc_o));
  c_err: cover property (pslverr_o);
  c_full: cover property ($fell(txclav_o[0]));
endmodule
bind ucp_cell_port ucp_cell_port_chk ucp_cell_port_chk_inst (.clk_i, .reset_n_i, .psel_i, .penable_i, .prdata_o,
  .pready_o, .pslverr_o, .txclk_i, .rxclk_i, .txclav_o, .rxdata_o, .rxprty_o, .rxsoc_o, .rxdata_oe_o);

// ==== test/ucp_atm_model.sv ====
// atm-layer model: free-running link clocks, polling, cell send and receive
// assumes the bench calls its tasks and wires its pins to the cell port
`timescale 1ns/100ps
module ucp_atm_model
(
  output reg         txclk_o,
  output reg  [15:0] txdata_o,
  output reg         txprty_o,
  output reg         txsoc_o,
  output reg  [4:0]  txaddr_o,
  output reg  [3:0]  txen_n_o,
  output reg         rxclk_o,
  output reg  [4:0]  rxaddr_o,
  output reg  [3:0]  rxen_n_o,
  input  wire [15:0] rxdata_i,
  input  wire        rxprty_i,
  input  wire        rxsoc_i
);
  reg [15:0] rx_word [0:26];
  reg [26:0] rx_soc;
  reg [26:0] rx_par;
  // set by the bench in 8-bit mode: parity then covers the low byte only
  reg        narrow = 1'b0;
  initial
  begin
    {txclk_o, txdata_o, txprty_o, txsoc_o, txaddr_o, rxclk_o, rxaddr_o} = 0;
    {txen_n_o, rxen_n_o} = 8'hFF;
    #170 forever #400 rxclk_o = ~rxclk_o;
  end
  always #400 txclk_o = ~txclk_o;
  function [15:0] wd(input integer n);
    wd = {n[7:0] ^ 8'h5A, n[7:0] + 8'h81};
  endfunction
  task poll(input [4:0] addr);
    begin
      @(negedge txclk_o);
      {txaddr_o, rxaddr_o} = {addr, addr};
      repeat (2) @(negedge txclk_o);
    end
  endtask
  // pins change mid-period so the rising link edge sees them settled
  task tx_cell(input [4:0] addr, input [3:0] en, input integer n, input integer gap);
    integer i;
    begin
      @(negedge txclk_o);
      txaddr_o = addr;
      @(negedge txclk_o);
      for (i = 0; i < n; i = i + 1)
      begin
        if (i == gap)
        begin
          {txen_n_o, txsoc_o, txdata_o} = {5'h1E, ~txdata_o};
          @(negedge txclk_o);
        end
        {txen_n_o, txsoc_o, txdata_o} = {~en, i == 0, wd(i)};
        txprty_o = narrow ? ~^txdata_o[7:0] : ~^txdata_o;
        @(negedge txclk_o);
      end
      {txen_n_o, txsoc_o, txdata_o} = {5'h1E, ~txdata_o};
    end
  endtask
  task rx_cell(input [4:0] addr);
    integer i;
    begin
      @(negedge rxclk_o);
      rxaddr_o = addr;
      @(negedge rxclk_o);
      rxen_n_o = 4'hE;
      for (i = 0; i < 28; i = i + 1)
      begin
        @(posedge rxclk_o);
        if (i > 0)
          {rx_soc[i-1], rx_par[i-1], rx_word[i-1]} = {rxsoc_i, rxprty_i, rxdata_i};
        if (i == 26)
          @(negedge rxclk_o) rxen_n_o = 4'hF;
      end
    end
  endtask
endmodule

// ==== test/ucp_cell_port_bench.sv ====
// self-checking bench of the cell port: apb master and scenario tasks
// assumes the atm model drives the link pins from its own clocks
`timescale 1ns/100ps
module ucp_cell_port_bench;
  reg         clk_i, reset_n_i, psel_i, penable_i, pwrite_i;
  reg  [7:0]  paddr_i;
  reg  [31:0] pwdata_i;
  reg  [1:0]  mode_i;
  wire [31:0] prdata_o;
  wire        pready_o, pslverr_o, txclk_i, txprty_i, txsoc_i, rxclk_i, rxprty_o, rxsoc_o, rxdata_oe_o;
  wire [15:0] txdata_i, rxdata_o;
  wire [4:0]  txaddr_i, rxaddr_i;
  wire [3:0]  txen_n_i, rxen_n_i, txclav_o, txclav_oe_o, rxclav_o, rxclav_oe_o;
  integer     miscompares, n_checks, i;
  ucp_cell_port ucp_cell_port_inst
  (
    .clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .mode_i, .txclk_i, .txdata_i, .txprty_i, .txsoc_i, .txaddr_i, .txen_n_i, .txclav_o,
    .txclav_oe_o, .rxclk_i, .rxaddr_i, .rxen_n_i, .rxdata_o, .rxprty_o, .rxsoc_o, .rxdata_oe_o,
    .rxclav_o, .rxclav_oe_o
  );
  ucp_atm_model ucp_atm_model_inst
  (
    .txclk_o(txclk_i), .txdata_o(txdata_i), .txprty_o(txprty_i), .txsoc_o(txsoc_i), .txaddr_o(txaddr_i),
    .txen_n_o(txen_n_i), .rxclk_o(rxclk_i), .rxaddr_o(rxaddr_i), .rxen_n_o(rxen_n_i),
    .rxdata_i(rxdata_o), .rxprty_i(rxprty_o), .rxsoc_i(rxsoc_o)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // request held until the rising edge that sees pready; data taken at that edge
  task apb(input wr, input [7:0] a, input [31:0] d, input [31:0] exp, input err);
    integer n;
    begin
      @(posedge clk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, wr, a, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && n < 40)
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (n == 40)
      begin
        miscompares = miscompares + 1;
        end_sim;
      end
      chk({31'h0, pslverr_o}, {31'h0, err});
      if (!wr)
        chk(prdata_o, exp);
      {psel_i, penable_i} <= 2'h0;
    end
  endtask
  task t_regs;
    begin
      apb(0, 8'h00, 0, 32'h0, 0);
      for (i = 0; i < 4; i = i + 1)
        apb(0, 8'h10 + {i[5:0], 2'h0}, 0, i, 0);
      apb(1, 8'h00, 32'h2, 0, 0);
      apb(0, 8'h00, 0, 32'h2, 0);
      apb(1, 8'h00, 32'h0, 0, 0);
      apb(1, 8'h18, 32'h15, 0, 0);
      apb(0, 8'h18, 0, 32'h15, 0);
      apb(1, 8'h40, 32'h1, 0, 1);
      apb(0, 8'h40, 0, 32'h0, 1);
      $display("registers done");
    end
  endtask
  task t_l2_tx;
    begin
      ucp_atm_model_inst.poll(5'h15);
      chk({txclav_oe_o, txclav_o[0]}, 5'h3);
      ucp_atm_model_inst.poll(5'h1E);
      chk({txclav_oe_o, rxclav_oe_o}, 8'h0);
      ucp_atm_model_inst.tx_cell(5'h15, 4'h1, 27, 9);
      repeat (16) @(posedge clk_i);
      apb(0, 8'h04, 0, 32'h40, 0);
      ucp_atm_model_inst.poll(5'h15);
      chk({txclav_oe_o, txclav_o[0]}, 5'h2);
      apb(1, 8'h20, 0, 0, 0);
      for (i = 0; i < 27; i = i + 1)
        apb(0, 8'h24, 0, {16'h0, ucp_atm_model_inst.wd(i)}, 0);
      apb(1, 8'h08, 32'h4, 0, 0);
      $display("transmit wide done");
    end
  endtask
  task t_l2_rx;
    begin
      apb(1, 8'h28, 0, 0, 0);
      for (i = 0; i < 27; i = i + 1)
        apb(1, 8'h2C, {16'h0, ucp_atm_model_inst.wd(i)}, 0, 0);
      apb(1, 8'h08, 32'h20, 0, 0);
      ucp_atm_model_inst.poll(5'h01);
      chk({rxclav_oe_o, rxclav_o[0]}, 5'h3);
      ucp_atm_model_inst.rx_cell(5'h01);
      for (i = 0; i < 27; i = i + 1)
        chk({ucp_atm_model_inst.rx_soc[i], ucp_atm_model_inst.rx_par[i], ucp_atm_model_inst.rx_word[i]},
          {i == 0, ~^ucp_atm_model_inst.wd(i), ucp_atm_model_inst.wd(i)});
      apb(0, 8'h04, 0, 32'h0, 0);
      $display("receive wide done");
    end
  endtask
  task t_l1;
    begin
      mode_i <= 2'h1;
      ucp_atm_model_inst.narrow = 1'b1;
      repeat (8) @(posedge clk_i);
      apb(0, 8'h04, 0, 32'h1, 0);
      ucp_atm_model_inst.tx_cell(5'h0, 4'h2, 52, 99);
      ucp_atm_model_inst.tx_cell(5'h0, 4'h2, 20, 99);
      repeat (16) @(posedge clk_i);
      apb(0, 8'h04, 0, 32'h1, 0);
      ucp_atm_model_inst.tx_cell(5'h0, 4'h2, 53, 99);
      repeat (16) @(posedge clk_i);
      apb(0, 8'h04, 0, 32'h21, 0);
      chk({txclav_oe_o, txclav_o}, 8'hFD);
      $display("narrow done");
    end
  endtask
  initial
  begin
    {reset_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, mode_i} = 0;
    {miscompares, n_checks} = 0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    t_regs;
    t_l2_tx;
    t_l2_rx;
    t_l1;
    end_sim;
  end
endmodule
